// *** rtl/uaf_pkg.sv ***
package uaf_pkg;
	// register offsets inside one channel window
	localparam logic [4:0] OFF_DATA = 5'h00;
	localparam logic [4:0] OFF_STAT = 5'h04;
	localparam logic [4:0] OFF_CTRL = 5'h08;
	localparam logic [4:0] OFF_BAUD = 5'h0c;
	localparam logic [4:0] OFF_XCHR = 5'h10;
	localparam int         CH_LSB   = 5;
	localparam int         NCH      = 3;
	localparam int         ADR_W    = 8;
	// control fields
	localparam int         C_WLEN   = 0;
	localparam int         C_PEN    = 2;
	localparam int         C_PEVEN  = 3;
	localparam int         C_PSTK   = 4;
	localparam int         C_STOP2  = 5;
	localparam int         C_BRK    = 6;
	localparam int         C_FEN    = 7;
	localparam int         C_HS     = 8;
	localparam int         C_XEN    = 9;
	localparam int         CTRL_W   = 10;
	localparam logic [9:0] CTRL_RST = 10'h083;
	// divisor: integer part above a 6-bit fraction, 115200 at 25 MHz
	localparam int          FRAC_W   = 6;
	localparam int          BINT_W   = 16;
	localparam logic [21:0] BAUD_RST = 22'h000364;
	localparam logic [15:0] XCHR_RST = 16'h1311;
	// oversampling factors
	localparam logic [4:0] OS_NORM  = 5'h10;
	localparam logic [4:0] OS_HIGH  = 5'h08;
	localparam logic [2:0] LAST_B   = 3'h4;
	localparam logic [2:0] WL_MAX   = 3'h3;
	localparam logic [7:0] WMASK_B  = 8'he0;
	// status bits
	localparam int         S_TXF    = 0;
	localparam int         S_TXE    = 1;
	localparam int         S_RXF    = 2;
	localparam int         S_RXE    = 3;
	localparam int         S_TXBSY  = 4;
	localparam int         S_HOLD   = 5;
	// receive entry flags above the byte
	localparam int         E_FE     = 8;
	localparam int         E_PE     = 9;
	localparam int         E_BK     = 10;
	localparam int         E_OV     = 11;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_DATA  = 3'b010,
		ST_PAR   = 3'b011,
		ST_STOP  = 3'b100,
		ST_WAIT  = 3'b101
	} uaf_bit_t;
endpackage

// *** rtl/uaf_top.sv ***
// Contract
// - three independent channels, own rx and tx
// - serial to parallel and parallel to serial
// - normal mode runs up to clock over 16
// - high speed mode runs up to clock over 8
// - divisor has a fractional part
// - 5 to 8 data bits, both directions
// - even, odd, stick or no parity
// - one or two stop bits sent
// - no one and a half stop bits
// - xon/xoff flow control with programmable characters
// - false start bit returns to idle unstored
// - drive break on tx, detect break on rx
// - tx fifo 8 bits by 64
// - rx fifo 12 bits by 64
// - entry carries break, frame, parity, overrun flags
// - fifos can be cut to one entry
// - no modem status delta indications
// - receiver shares the transmit baud tick
`timescale 1ns/1ns

module uaf_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 64
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         one_i,
	input  wire logic         push_i,
	input  wire logic [W-1:0] din_i,
	input  wire logic         pop_i,
	output logic      [W-1:0] dout_o,
	output logic              full_o,
	output logic              empty_o,
	output logic [$clog2(DEPTH):0] cnt_o
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0]   cnt_q;
	logic          wr, rd;

	assign full_o  = one_i ? (cnt_q != '0) : (cnt_q == (AW+1)'(DEPTH));
	assign empty_o = (cnt_q == '0);
	assign dout_o  = mem_q[rp_q];
	assign cnt_o   = cnt_q;
	assign wr      = push_i && !full_o;
	assign rd      = pop_i && !empty_o;

	always_ff @(posedge clk_i) begin
		if (wr) begin
			mem_q[wp_q] <= din_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (wr) begin
				wp_q <= wp_q + 1'b1;
			end
			if (rd) begin
				rp_q <= rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end
endmodule

module uaf_channel
	import uaf_pkg::*;
#(
	parameter int DEPTH = 64
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// register access from the bus slave
	input  wire logic        reg_we_i,
	input  wire logic        reg_re_i,
	input  wire logic [4:0]  reg_off_i,
	input  wire logic [3:0]  reg_sel_i,
	input  wire logic [31:0] reg_wdat_i,
	output logic      [31:0] reg_rdat_o,
	// serial lines
	input  wire logic        rx_i,
	output logic             tx_o
);
	logic [CTRL_W-1:0] ctrl_q;
	logic [21:0] baud_q;
	logic [15:0] xchr_q;
	logic [31:0] wmask, wval;
	logic [1:0]  wl;
	logic [4:0]  os, os_m1, half_m1;
	logic        tick, hold_q, ovr_q;
	logic [15:0] bcnt_q;
	logic [FRAC_W-1:0] bacc_q;
	logic [FRAC_W:0]   bsum;

	assign wl      = ctrl_q[C_WLEN +: 2];
	assign os      = ctrl_q[C_HS] ? OS_HIGH : OS_NORM;
	assign os_m1   = os - 5'h01;
	assign half_m1 = (os >> 1) - 5'h01;
	assign wmask   = {{8{reg_sel_i[3]}}, {8{reg_sel_i[2]}}, {8{reg_sel_i[1]}}, {8{reg_sel_i[0]}}};

	function automatic logic par_bit(input logic [7:0] d, input logic [1:0] w,
		input logic ev, input logic st);
		logic p;
		p = ^(d & ~(WMASK_B << w));
		par_bit = st ? !ev : (ev ? p : !p);
	endfunction

	// ---------------- registers
	always_comb begin
		wval = 32'h0;
		unique case (reg_off_i)
			OFF_CTRL: wval = {22'h0, ctrl_q};
			OFF_BAUD: wval = {10'h0, baud_q};
			OFF_XCHR: wval = {16'h0, xchr_q};
			default:  wval = 32'h0;
		endcase
		wval = (wval & ~wmask) | (reg_wdat_i & wmask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RST;
			baud_q <= BAUD_RST;
			xchr_q <= XCHR_RST;
		end else if (reg_we_i) begin
			if (reg_off_i == OFF_CTRL) begin
				ctrl_q <= wval[CTRL_W-1:0];
			end
			if (reg_off_i == OFF_BAUD) begin
				baud_q <= wval[21:0];
			end
			if (reg_off_i == OFF_XCHR) begin
				xchr_q <= wval[15:0];
			end
		end
	end

	// ---------------- fractional baud tick, one tick per oversample
	assign tick = (bcnt_q == 16'h0);
	assign bsum = {1'b0, bacc_q} + {1'b0, baud_q[FRAC_W-1:0]};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bcnt_q <= 16'h0;
			bacc_q <= '0;
		end else if (tick) begin
			// fraction overflow stretches this period by one clock
			bacc_q <= bsum[FRAC_W-1:0];
			bcnt_q <= baud_q[21:FRAC_W] - 16'h0001 + {15'h0, bsum[FRAC_W]};
		end else begin
			bcnt_q <= bcnt_q - 16'h0001;
		end
	end

	// ---------------- fifos
	logic [7:0]  tx_dout;
	logic [11:0] rx_dout, rx_ent;
	logic        tx_full, tx_empty, rx_full, rx_empty, tx_push, tx_pop, rx_push, rx_pop;
	logic [$clog2(DEPTH):0] tx_cnt, rx_cnt;
	// declared here: the status read below already looks at it
	uaf_bit_t    tx_st_q;

	assign tx_push = reg_we_i && reg_off_i == OFF_DATA && reg_sel_i[0];
	assign rx_pop  = reg_re_i && reg_off_i == OFF_DATA;

	uaf_fifo #(.W(8), .DEPTH(DEPTH)) u_txf (
		.clk_i(clk_i), .rst_i(rst_i), .one_i(!ctrl_q[C_FEN]), .push_i(tx_push),
		.din_i(reg_wdat_i[7:0]), .pop_i(tx_pop), .dout_o(tx_dout), .full_o(tx_full),
		.empty_o(tx_empty), .cnt_o(tx_cnt));

	uaf_fifo #(.W(12), .DEPTH(DEPTH)) u_rxf (
		.clk_i(clk_i), .rst_i(rst_i), .one_i(!ctrl_q[C_FEN]), .push_i(rx_push),
		.din_i(rx_ent), .pop_i(rx_pop), .dout_o(rx_dout), .full_o(rx_full),
		.empty_o(rx_empty), .cnt_o(rx_cnt));

	always_comb begin
		unique case (reg_off_i)
			OFF_DATA: reg_rdat_o = rx_empty ? 32'h0 : {20'h0, rx_dout};
			// plain levels only, nothing change-detected
			OFF_STAT: reg_rdat_o = {26'h0, hold_q, tx_st_q != ST_IDLE, rx_empty,
				rx_full, tx_empty, tx_full};
			OFF_CTRL: reg_rdat_o = {22'h0, ctrl_q};
			OFF_BAUD: reg_rdat_o = {10'h0, baud_q};
			OFF_XCHR: reg_rdat_o = {16'h0, xchr_q};
			default:  reg_rdat_o = 32'h0;
		endcase
	end

	// ---------------- transmitter
	logic [7:0] tx_sh_q;
	logic [4:0] tx_os_q;
	logic [2:0] tx_bit_q;
	logic       txd_q, tx_par_q, tx_end;

	assign tx_end = tick && tx_os_q == os_m1;
	// flow control holds only the start of the next character
	assign tx_pop = tx_st_q == ST_IDLE && !tx_empty && !hold_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_os_q <= 5'h0;
		end else if (tx_st_q == ST_IDLE) begin
			tx_os_q <= 5'h0;
		end else if (tick) begin
			tx_os_q <= tx_end ? 5'h0 : tx_os_q + 5'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_st_q  <= ST_IDLE;
			tx_sh_q  <= 8'h0;
			tx_bit_q <= 3'h0;
			tx_par_q <= 1'b0;
			txd_q    <= 1'b1;
		end else begin
			unique case (tx_st_q)
				ST_IDLE: if (tx_pop) begin
					tx_st_q  <= ST_START;
					tx_sh_q  <= tx_dout;
					tx_par_q <= par_bit(tx_dout, wl, ctrl_q[C_PEVEN], ctrl_q[C_PSTK]);
					txd_q    <= 1'b0;
				end
				ST_START: if (tx_end) begin
					tx_st_q  <= ST_DATA;
					tx_bit_q <= 3'h0;
					txd_q    <= tx_sh_q[0];
				end
				ST_DATA: if (tx_end) begin
					if (tx_bit_q == {1'b0, wl} + LAST_B) begin
						tx_st_q  <= ctrl_q[C_PEN] ? ST_PAR : ST_STOP;
						txd_q    <= ctrl_q[C_PEN] ? tx_par_q : 1'b1;
						tx_bit_q <= 3'h0;
					end else begin
						tx_bit_q <= tx_bit_q + 3'h1;
						tx_sh_q  <= tx_sh_q >> 1;
						txd_q    <= tx_sh_q[1];
					end
				end
				ST_PAR: if (tx_end) begin
					tx_st_q <= ST_STOP;
					txd_q   <= 1'b1;
				end
				ST_STOP: if (tx_end) begin
					if (ctrl_q[C_STOP2] && tx_bit_q == 3'h0) begin
						tx_bit_q <= 3'h1;
					end else begin
						tx_st_q <= ST_IDLE;
					end
				end
				default: tx_st_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_o <= 1'b1;
		end else begin
			tx_o <= txd_q && !ctrl_q[C_BRK];
		end
	end

	// ---------------- receiver
	uaf_bit_t   rx_st_q;
	logic       rx_s1_q, rx_s2_q, rx_p_q, rx_pe_q, rx_z_q, rx_smp;
	logic [7:0] rx_sh_q, rx_byte;
	logic [4:0] rx_os_q;
	logic [2:0] rx_bit_q;
	logic       rx_fe, rx_bk, rx_flow;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end else begin
			rx_s1_q <= rx_i;
			rx_s2_q <= rx_s1_q;
		end
	end

	// same tick as the transmitter, no own receive clock
	assign rx_smp  = tick && rx_os_q == os_m1;
	assign rx_byte = rx_sh_q >> (WL_MAX - {1'b0, wl});
	assign rx_fe   = !rx_s2_q;
	assign rx_bk   = rx_fe && rx_z_q;
	assign rx_flow = ctrl_q[C_XEN] && !rx_fe && !rx_pe_q &&
		(rx_byte == xchr_q[15:8] || rx_byte == xchr_q[7:0]);
	assign rx_push = rx_st_q == ST_STOP && rx_smp && !rx_flow;
	assign rx_ent  = {ovr_q, rx_bk, rx_pe_q, rx_fe, rx_byte};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_os_q <= 5'h0;
		end else if (rx_st_q == ST_IDLE || (rx_st_q == ST_START && tick && rx_os_q == half_m1)) begin
			rx_os_q <= 5'h0;
		end else if (tick) begin
			rx_os_q <= rx_smp ? 5'h0 : rx_os_q + 5'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_st_q  <= ST_IDLE;
			rx_sh_q  <= 8'h0;
			rx_bit_q <= 3'h0;
			rx_p_q   <= 1'b0;
			rx_pe_q  <= 1'b0;
			rx_z_q   <= 1'b0;
		end else begin
			unique case (rx_st_q)
				ST_IDLE: if (!rx_s2_q) begin
					rx_st_q <= ST_START;
				end
				ST_START: if (tick && rx_os_q == half_m1) begin
					// line back high at mid start: glitch, not a character
					rx_st_q  <= rx_s2_q ? ST_IDLE : ST_DATA;
					rx_bit_q <= 3'h0;
					rx_p_q   <= 1'b0;
					rx_pe_q  <= 1'b0;
					rx_z_q   <= 1'b1;
				end
				ST_DATA: if (rx_smp) begin
					rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
					rx_p_q  <= rx_p_q ^ rx_s2_q;
					rx_z_q  <= rx_z_q && !rx_s2_q;
					if (rx_bit_q == {1'b0, wl} + LAST_B) begin
						rx_st_q <= ctrl_q[C_PEN] ? ST_PAR : ST_STOP;
					end else begin
						rx_bit_q <= rx_bit_q + 3'h1;
					end
				end
				ST_PAR: if (rx_smp) begin
					rx_st_q <= ST_STOP;
					rx_z_q  <= rx_z_q && !rx_s2_q;
					rx_pe_q <= rx_s2_q != (ctrl_q[C_PSTK] ? !ctrl_q[C_PEVEN] :
						(ctrl_q[C_PEVEN] ? rx_p_q : !rx_p_q));
				end
				ST_STOP: if (rx_smp) begin
					// a low stop waits for the line to rise before rearming
					rx_st_q <= rx_fe ? ST_WAIT : ST_IDLE;
				end
				ST_WAIT: if (rx_s2_q) begin
					rx_st_q <= ST_IDLE;
				end
				default: rx_st_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_q <= 1'b0;
		end else if (!ctrl_q[C_XEN]) begin
			hold_q <= 1'b0;
		end else if (rx_st_q == ST_STOP && rx_smp && rx_flow) begin
			hold_q <= rx_byte == xchr_q[15:8];
		end
	end

	// overrun is reported on the next character that fits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovr_q <= 1'b0;
		end else if (rx_push) begin
			ovr_q <= rx_full;
		end
	end

	// ---------------- checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_glitch;
		rx_st_q == ST_START && tick && rx_os_q == half_m1 && rx_s2_q;
	endsequence

	sequence s_stop1_end;
		tx_st_q == ST_STOP && tx_end && ctrl_q[C_STOP2] && tx_bit_q == 3'h0;
	endsequence

	a_idle_high: assert property (tx_st_q == ST_IDLE && !ctrl_q[C_BRK] |=> tx_o)
		else $error("idle line not high");
	a_start_low: assert property (tx_st_q == ST_START |=> !tx_o)
		else $error("start bit not low");
	a_break_drive: assert property (ctrl_q[C_BRK] |=> !tx_o)
		else $error("break not driven");
	a_two_stop: assert property (s_stop1_end |=> tx_st_q == ST_STOP [*2])
		else $error("second stop bit skipped");
	a_false_start: assert property (s_glitch |=> rx_st_q == ST_IDLE && rx_cnt == $past(rx_cnt))
		else $error("false start not rejected");
	a_frame_err: assert property (rx_push |-> rx_ent[E_FE] == !rx_s2_q)
		else $error("frame flag wrong");
	a_fifo_one: assert property (!ctrl_q[C_FEN] && !$past(ctrl_q[C_FEN]) |-> tx_cnt <= 1)
		else $error("disabled fifo holds more than one");
	a_rx_pop: assert property (rx_pop && !rx_empty && !rx_push |=> rx_cnt == $past(rx_cnt) - 1)
		else $error("rx read did not pop");
endmodule

module uaf_top
	import uaf_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// wishbone classic slave
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	// serial lines, one per channel
	input  wire logic [NCH-1:0]   serial_in_line_i,
	output logic      [NCH-1:0]   serial_out_line_o
);
	logic        take;
	logic [1:0]  ch;
	logic [31:0] rdat [NCH];

	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign ch   = wb_adr_i[CH_LSB +: 2];

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		uaf_channel u_ch (
			.clk_i      (clk_i),
			.rst_i      (rst_i),
			// upper half of the address space is unmapped: no write, no pop
			.reg_we_i   (take && wb_we_i && !wb_adr_i[ADR_W-1] && ch == 2'(i)),
			.reg_re_i   (take && !wb_we_i && !wb_adr_i[ADR_W-1] && ch == 2'(i)),
			.reg_off_i  (wb_adr_i[4:0]),
			.reg_sel_i  (wb_sel_i),
			.reg_wdat_i (wb_dat_i),
			.reg_rdat_o (rdat[i]),
			.rx_i       (serial_in_line_i[i]),
			.tx_o       (serial_out_line_o[i])
		);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= take;
			if (take) begin
				wb_dat_o <= (wb_we_i || ch >= 2'(NCH) || wb_adr_i[ADR_W-1]) ? 32'h0 : rdat[ch];
			end
		end
	end
endmodule

// *** testbench/uaf_peer.sv ***
`timescale 1ns/1ns

module uaf_peer (
	// clock
	input  wire logic       clk_i,
	// serial lines as seen from the far side
	input  wire logic [2:0] tx_i,
	output logic      [2:0] rx_o
);
	initial rx_o = 3'h7;

	// bits go out lsb first; line returns high after the frame
	task automatic send(input int ch, input logic [15:0] b, input int n, input int per);
		@(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			rx_o[ch] <= b[i];
			repeat (per) @(posedge clk_i);
		end
		rx_o[ch] <= 1'b1;
	endtask

	// samples mid-bit from the falling start edge; a missed start reads as high
	task automatic recv(input int ch, input int n, input int per, output logic [15:0] b);
		int t;
		b = 16'hffff;
		t = 0;
		while (tx_i[ch] !== 1'b0 && t < 2000) begin
			@(posedge clk_i);
			t++;
		end
		repeat (per / 2) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			b[i] = tx_i[ch];
			repeat (per) @(posedge clk_i);
		end
	endtask
endmodule

// *** testbench/uaf_top_tb.sv ***
`timescale 1ns/1ns

module uaf_top_tb
	import uaf_pkg::*;
;
	logic             clk_i   = 1'b0;
	logic             rst_i   = 1'b1;
	logic             wb_cyc  = 1'b0;
	logic             wb_stb  = 1'b0;
	logic             wb_we   = 1'b0;
	logic [ADR_W-1:0] wb_adr  = 8'h00;
	logic [31:0]      wb_wdat = 32'h0;
	logic [31:0]      wb_rdat;
	logic             wb_ack;
	logic [NCH-1:0]   rx_line;
	logic [NCH-1:0]   tx_line;
	int               fail_count      = 0;
	int               samples_checked = 0;
	int               nb;
	logic [31:0]      rd;
	logic [15:0]      fb;
	logic [15:0]      gv;
	logic             lo;
	logic [9:0]       mc [7] = '{10'h083, 10'h0a0, 10'h08d, 10'h086, 10'h09f, 10'h097, 10'h183};
	logic [7:0]       md [7] = '{8'ha5, 8'h3f, 8'h2c, 8'h55, 8'h81, 8'h00, 8'h5a};
	logic [4:0]       ro [5] = '{OFF_CTRL, OFF_BAUD, OFF_XCHR, OFF_STAT, 5'h14};
	logic [31:0]      re [5] = '{{22'h0, CTRL_RST}, {10'h0, BAUD_RST}, {16'h0, XCHR_RST},
		32'h0a, 32'h0};

	always #20 clk_i = ~clk_i;

	uaf_top uaf_top_i (
		.clk_i            (clk_i),
		.rst_i            (rst_i),
		.wb_cyc_i         (wb_cyc),
		.wb_stb_i         (wb_stb),
		.wb_we_i          (wb_we),
		.wb_adr_i         (wb_adr),
		.wb_sel_i         (4'hf),
		.wb_dat_i         (wb_wdat),
		.wb_dat_o         (wb_rdat),
		.wb_ack_o         (wb_ack),
		.serial_in_line_i (rx_line),
		.serial_out_line_o(tx_line)
	);

	uaf_peer uaf_peer_i (
		.clk_i(clk_i),
		.tx_i (tx_line),
		.rx_o (rx_line)
	);

	task automatic finish_test;
		if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
			fail_count++;
		end
	endtask

	// one classic cycle; read data is taken at the ack edge only
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_wdat <= d;
		do begin
			@(posedge clk_i);
			t++;
		end while (wb_ack !== 1'b1 && t < 50);
		rd = wb_rdat;
		chk("wb_ack", 32'h1, {31'h0, wb_ack});
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	function automatic logic [7:0] ad(input int ch, input logic [4:0] o);
		ad = {1'b0, ch[1:0], o};
	endfunction

	// whole frame for a control word; leaves its bit count in nb
	function automatic logic [15:0] frm(input logic [9:0] c, input logic [7:0] d);
		logic [7:0] m;
		logic       p;
		m = d & (8'hff >> (3 - c[1:0]));
		nb = 5 + c[1:0];
		p = c[C_PSTK] ? ~c[C_PEVEN] : (^m ^ ~c[C_PEVEN]);
		frm = 16'hffff;
		frm[0] = 1'b0;
		for (int i = 0; i < 8; i++) if (i < nb) frm[1 + i] = m[i];
		if (c[C_PEN]) frm[1 + nb] = p;
		nb = nb + 2 + c[C_PEN] + c[C_STOP2];
	endfunction

	task automatic rxchk(input int ch, input logic [15:0] b, input int n, input int per,
		input logic [31:0] e, input logic [31:0] m);
		int t;
		t = 0;
		uaf_peer_i.send(ch, b, n, per);
		do begin
			wb(1'b0, ad(ch, OFF_STAT), 32'h0);
			t++;
		end while (rd[S_RXE] !== 1'b0 && t < 40);
		wb(1'b0, ad(ch, OFF_DATA), 32'h0);
		chk("rx entry", e, rd & m);
	endtask

	task automatic txrx(input int ch, input logic [9:0] c, input logic [7:0] d, input int per);
		logic [15:0] got;
		logic [15:0] ef;
		logic [15:0] mk;
		ef = frm(c, d);
		mk = ~(16'hffff << nb);
		wb(1'b1, ad(ch, OFF_CTRL), {22'h0, c});
		fork
			uaf_peer_i.recv(ch, nb, per, got);
			wb(1'b1, ad(ch, OFF_DATA), {24'h0, d});
		join
		chk("tx frame", ef & mk, got & mk);
		rxchk(ch, ef, nb, per, {24'h0, d & (8'hff >> (3 - c[1:0]))}, 32'hfff);
	endtask

	initial begin
		repeat (60000) @(posedge clk_i);
		fail_count++;
		finish_test;
	end

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			wb(1'b0, ad(1, ro[i]), 32'h0);
			chk("reset value", re[i], rd);
		end
		wb(1'b0, 8'h60, 32'h0);
		chk("fourth channel", 32'h0, rd);
		// fastest tick: one per clock, so a bit is the oversampling factor in clocks
		for (int i = 0; i < 3; i++) wb(1'b1, ad(i, OFF_BAUD), 32'h40);
		for (int i = 0; i < 7; i++) begin
			txrx(i % 3, mc[i], md[i], mc[i][C_HS] ? 8 : 16);
		end
		wb(1'b1, ad(0, OFF_CTRL), 32'h08f);
		fb = frm(10'h08f, 8'h3c);
		fb[9] = ~fb[9];
		rxchk(0, fb, 11, 16, 32'h23c, 32'hfff);
		fb = frm(10'h08f, 8'h3c);
		fb[10] = 1'b0;
		rxchk(0, fb, 11, 16, 32'h13c, 32'hfff);
		rxchk(0, 16'h0000, 16, 16, 32'h400, 32'h400);
		uaf_peer_i.send(0, 16'h0000, 1, 4);
		// longer than a whole frame, so a wrongly kept start would have landed
		repeat (300) @(posedge clk_i);
		wb(1'b0, ad(0, OFF_STAT), 32'h0);
		chk("false start", 32'h1, {31'h0, rd[S_RXE]});
		wb(1'b1, ad(1, OFF_CTRL), 32'h003);
		uaf_peer_i.send(1, frm(10'h003, 8'h61), 10, 16);
		uaf_peer_i.send(1, frm(10'h003, 8'h62), 10, 16);
		wb(1'b0, ad(1, OFF_DATA), 32'h0);
		chk("one deep", 32'h061, rd & 32'hfff);
		rxchk(1, frm(10'h003, 8'h63), 10, 16, 32'h863, 32'hfff);
		wb(1'b1, ad(2, OFF_CTRL), 32'h083);
		repeat (66) wb(1'b1, ad(2, OFF_DATA), 32'h55);
		wb(1'b0, ad(2, OFF_STAT), 32'h0);
		chk("tx full", 32'h1, rd & 32'h1);
		// the fifo empties one character before the shifter goes idle
		for (int t = 0; t < 6000 && (rd & 32'h12) !== 32'h02; t++) begin
			wb(1'b0, ad(2, OFF_STAT), 32'h0);
		end
		chk("tx drained", 32'h02, rd & 32'h13);
		wb(1'b1, ad(0, OFF_CTRL), 32'h0c3);
		repeat (40) @(posedge clk_i);
		chk("break out", 32'h0, {31'h0, tx_line[0]});
		wb(1'b1, ad(0, OFF_CTRL), 32'h083);
		repeat (4) @(posedge clk_i);
		chk("break end", 32'h1, {31'h0, tx_line[0]});
		// custom flow characters, so reset values cannot pass by luck
		wb(1'b1, ad(1, OFF_XCHR), 32'h5a3c);
		wb(1'b1, ad(1, OFF_CTRL), 32'h283);
		uaf_peer_i.send(1, frm(10'h083, 8'h5a), 10, 16);
		repeat (20) @(posedge clk_i);
		wb(1'b0, ad(1, OFF_STAT), 32'h0);
		chk("xoff held", 32'h28, rd & 32'h28);
		wb(1'b1, ad(1, OFF_DATA), 32'h77);
		lo = 1'b0;
		repeat (300) begin
			@(posedge clk_i);
			lo = lo | ~tx_line[1];
		end
		chk("xoff quiet", 32'h0, {31'h0, lo});
		fork
			uaf_peer_i.recv(1, 10, 16, gv);
			uaf_peer_i.send(1, frm(10'h083, 8'h3c), 10, 16);
		join
		chk("xon resume", {16'h0, frm(10'h083, 8'h77)}, {16'h0, gv | 16'hfc00});
		wb(1'b1, ad(2, OFF_BAUD), 32'ha0);
		txrx(2, 10'h083, 8'hc3, 40);
		finish_test;
	end
endmodule
